// [core/gpio_port.sv]
// Eight-bit port D and four-bit port E pin logic with AXI4-Lite registers.
// Assumes pin inputs already Schmitt-buffered and synchronous to aclk.
//
// What this block does
// R01: Port E pin state in one byte register
// R02: Three low port E pins individually input/output
// R03: Input-only pin readable only without master clear
// R04: Input-only pin direction bit always reads one
// R05: Upper four port E bits read zero
// R06: Direction bits 2-0 steer the bidirectional pins
// R07: Pin register bit follows pin logic level
// R08: Each bidirectional pin: digital, analog input or segment
// R09: Input-only pin: reset with pull-up, or input
// R10: LCD module may tri-state its segment outputs
// R11: Software clears analog select for digital use
// R12: Segment enables cleared only on power-on reset
// R13: Direction one means input, zero drives latch
// R14: Every reset sets all direction bits to input
//
// The AXI4-Lite register port was decided locally.
module gpio_port (
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   input  wire logic                               power_on_reset,
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]   awaddr,
   input  wire logic                               awvalid,
   output logic                                    awready,
   input  wire logic [gpio_port_pkg::DATA_W-1:0]   wdata,
   input  wire logic [3:0]                         wstrb,
   input  wire logic                               wvalid,
   output logic                                    wready,
   output logic [1:0]                              bresp,
   output logic                                    bvalid,
   input  wire logic                               bready,
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]   araddr,
   input  wire logic                               arvalid,
   output logic                                    arready,
   output logic [gpio_port_pkg::DATA_W-1:0]        rdata,
   output logic [1:0]                              rresp,
   output logic                                    rvalid,
   input  wire logic                               rready,
   input  wire logic [gpio_port_pkg::PORT_D_W-1:0] port_d_in,
   output logic      [gpio_port_pkg::PORT_D_W-1:0] port_d_out,
   output logic      [gpio_port_pkg::PORT_D_W-1:0] port_d_oe,
   input  wire logic [gpio_port_pkg::PORT_E_W-1:0] bidirectional_pins_in,
   output logic      [gpio_port_pkg::PORT_E_W-1:0] bidirectional_pins_out,
   output logic      [gpio_port_pkg::PORT_E_W-1:0] bidirectional_pins_oe,
   input  wire logic                               input_only_pin,
   input  wire logic [7:0]                         lcd_segment_out,
   input  wire logic [7:0]                         lcd_segment_oe,
   output logic [gpio_port_pkg::PORT_E_W-1:0]      analog_input_connect,
   output logic                                    master_clear_reset,
   output logic                                    weak_pullup_enable
);
   gpio_port_pkg::port_regs_t r_q;
   gpio_port_pkg::port_regs_t r_d;

   reg_access_if regs ();

   logic [gpio_port_pkg::PORT_D_W-1:0] d_seg_en;
   logic [gpio_port_pkg::PORT_D_W-1:0] d_seg_out;
   logic [gpio_port_pkg::PORT_D_W-1:0] d_seg_oe;
   logic [gpio_port_pkg::PORT_D_W-1:0] d_digital;
   logic [gpio_port_pkg::PORT_E_W-1:0] e_seg_en;
   logic [gpio_port_pkg::PORT_E_W-1:0] e_seg_out;
   logic [gpio_port_pkg::PORT_E_W-1:0] e_seg_oe;
   logic [gpio_port_pkg::PORT_E_W-1:0] e_analog;
   logic [gpio_port_pkg::PORT_E_W-1:0] e_digital;
   logic                               input_only_visible;

   axil_reg_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .regs    (regs.bus)
   );

   // Segment enables: low five bits serve port D pins 7-3, high three port E
   assign d_seg_en  = {r_q.segment_high[gpio_port_pkg::SEG_D_COUNT-1:0],
                       3'h0};
   assign d_seg_out = {lcd_segment_out[gpio_port_pkg::SEG_D_COUNT-1:0], 3'h0};
   assign d_seg_oe  = {lcd_segment_oe[gpio_port_pkg::SEG_D_COUNT-1:0], 3'h0};
   assign e_seg_en  = r_q.segment_high[7:gpio_port_pkg::SEG_E_LSB];          // R08
   assign e_seg_out = lcd_segment_out[7:gpio_port_pkg::SEG_E_LSB];
   assign e_seg_oe  = lcd_segment_oe[7:gpio_port_pkg::SEG_E_LSB];
   assign e_analog  = r_q.analog_sel[7:gpio_port_pkg::ANALOG_E_LSB];         // R08 R11

   pin_mux #(
      .WIDTH (gpio_port_pkg::PORT_D_W)
   ) u_port_d (
      .latch      (r_q.latch_d),
      .dir        (r_q.dir_d),
      .seg_en     (d_seg_en),
      .seg_out    (d_seg_out),
      .seg_oe     (d_seg_oe),
      .analog_en  (8'h00),
      .pin_in     (port_d_in),
      .pin_out    (port_d_out),
      .pin_oe     (port_d_oe),
      .digital_in (d_digital)
   );

   pin_mux #(
      .WIDTH (gpio_port_pkg::PORT_E_W)
   ) u_port_e (
      .latch      (r_q.latch_e),
      .dir        (r_q.dir_e),                                               // R06
      .seg_en     (e_seg_en),
      .seg_out    (e_seg_out),
      .seg_oe     (e_seg_oe),                                                // R10
      .analog_en  (e_analog),
      .pin_in     (bidirectional_pins_in),
      .pin_out    (bidirectional_pins_out),                                  // R02
      .pin_oe     (bidirectional_pins_oe),                                   // R13
      .digital_in (e_digital)                                                // R07
   );

   // Analog converter sees a pin only while it is analog-selected
   assign analog_input_connect = e_analog;                                   // R08

   // Input-only pin: reset line with pull-up, or a plain digital input
   assign input_only_visible = input_only_pin & ~r_q.master_clear_reset_enable;            // R03
   assign master_clear_reset = r_q.master_clear_reset_enable & ~input_only_pin;            // R09
   assign weak_pullup_enable = r_q.master_clear_reset_enable;                              // R09

   // Register read path
   always_comb begin
      case (regs.rd_idx)
         gpio_port_pkg::IDX_PORT_D_PIN: begin
            regs.rd_data = d_digital;
         end
         gpio_port_pkg::IDX_PORT_E_PIN: begin
            regs.rd_data = {4'h0, input_only_visible, e_digital};           // R01 R05
         end
         gpio_port_pkg::IDX_PORT_D_DIR: begin
            regs.rd_data = r_q.dir_d;
         end
         gpio_port_pkg::IDX_PORT_E_DIR: begin
            regs.rd_data = {4'h0, 1'b1, r_q.dir_e};                          // R04 R05
         end
         gpio_port_pkg::IDX_ANALOG_SEL: begin
            regs.rd_data = r_q.analog_sel;
         end
         gpio_port_pkg::IDX_SEGMENT_HIGH: begin
            regs.rd_data = r_q.segment_high;
         end
         gpio_port_pkg::IDX_DEVICE_CFG: begin
            regs.rd_data = {7'h00, r_q.master_clear_reset_enable};
         end
         default: begin
            regs.rd_data = 8'h00;
         end
      endcase
   end

   // Register writes and resets
   always_comb begin
      r_d = r_q;
      if (regs.wr_en) begin
         case (regs.wr_idx)
            gpio_port_pkg::IDX_PORT_D_PIN: begin
               r_d.latch_d = regs.wr_data;
            end
            gpio_port_pkg::IDX_PORT_E_PIN: begin
               r_d.latch_e = regs.wr_data[2:0];
            end
            gpio_port_pkg::IDX_PORT_D_DIR: begin
               r_d.dir_d = regs.wr_data;
            end
            gpio_port_pkg::IDX_PORT_E_DIR: begin
               r_d.dir_e = regs.wr_data[2:0];                                // R02 R04
            end
            gpio_port_pkg::IDX_ANALOG_SEL: begin
               r_d.analog_sel = regs.wr_data;                                // R11
            end
            gpio_port_pkg::IDX_SEGMENT_HIGH: begin
               r_d.segment_high = regs.wr_data;
            end
            gpio_port_pkg::IDX_DEVICE_CFG: begin
               r_d.master_clear_reset_enable = regs.wr_data[gpio_port_pkg::CFG_MASTER_CLEAR_ENABLE_BIT];
            end
            default: begin
               r_d = r_q;
            end
         endcase
      end
      if (!aresetn || power_on_reset) begin
         r_d.dir_d       = gpio_port_pkg::RST_PORT_D_DIR;                    // R14
         r_d.dir_e       = gpio_port_pkg::RST_PORT_E_DIR;                    // R14
         r_d.analog_sel  = gpio_port_pkg::RST_ANALOG_SEL;
         r_d.master_clear_reset_enable = gpio_port_pkg::RST_MASTER_CLEAR_RESET_ENABLE;
      end
      if (power_on_reset) begin
         r_d.segment_high = gpio_port_pkg::RST_SEGMENT_HIGH;                 // R12
         r_d.latch_d      = gpio_port_pkg::RST_PORT_D_LATCH;
         r_d.latch_e      = gpio_port_pkg::RST_PORT_E_LATCH;
      end
   end

   always_ff @(posedge aclk) begin
      r_q <= r_d;
   end
endmodule : gpio_port

// [include/gpio_port_pkg.sv]
// Constants, register map and state types shared by the port blocks.
// Assumes byte-wide registers reached as 32-bit words, byte address = index * 4.
package gpio_port_pkg;

   localparam int unsigned ADDR_W     = 12;
   localparam int unsigned IDX_W      = 10;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned REG_W      = 8;
   localparam int unsigned PORT_D_W   = 8;
   localparam int unsigned PORT_E_W   = 3;

   // Register indices
   localparam logic [IDX_W-1:0] IDX_PORT_D_PIN   = 10'h008;
   localparam logic [IDX_W-1:0] IDX_PORT_E_PIN   = 10'h009;
   localparam logic [IDX_W-1:0] IDX_PORT_D_DIR   = 10'h088;
   localparam logic [IDX_W-1:0] IDX_PORT_E_DIR   = 10'h089;
   localparam logic [IDX_W-1:0] IDX_ANALOG_SEL   = 10'h091;
   localparam logic [IDX_W-1:0] IDX_SEGMENT_HIGH = 10'h11E;
   localparam logic [IDX_W-1:0] IDX_DEVICE_CFG   = 10'h120;

   // Values after reset
   localparam logic [7:0] RST_PORT_D_DIR   = 8'hFF;
   localparam logic [2:0] RST_PORT_E_DIR   = 3'h7;
   localparam logic [7:0] RST_PORT_D_LATCH = 8'h00;
   localparam logic [2:0] RST_PORT_E_LATCH = 3'h0;
   localparam logic [7:0] RST_ANALOG_SEL   = 8'hFF;
   localparam logic [7:0] RST_SEGMENT_HIGH = 8'h00;
   localparam logic       RST_MASTER_CLEAR_RESET_ENABLE  = 1'h1;

   // Field positions
   localparam int unsigned ANALOG_E_LSB   = 5;
   localparam int unsigned SEG_E_LSB      = 5;
   localparam int unsigned SEG_D_COUNT    = 5;
   localparam int unsigned SEG_D_PIN_LSB  = 3;
   localparam int unsigned CFG_MASTER_CLEAR_ENABLE_BIT  = 0;
   localparam int unsigned INPUT_ONLY_BIT = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [7:0] latch_d;
      logic [7:0] dir_d;
      logic [2:0] latch_e;
      logic [2:0] dir_e;
      logic [7:0] analog_sel;
      logic [7:0] segment_high;
      logic       master_clear_reset_enable;
   } port_regs_t;

   // Decodes whether a word index holds a register
   function automatic logic reg_mapped(input logic [IDX_W-1:0] idx);
      case (idx)
         IDX_PORT_D_PIN, IDX_PORT_E_PIN, IDX_PORT_D_DIR, IDX_PORT_E_DIR,
         IDX_ANALOG_SEL, IDX_SEGMENT_HIGH, IDX_DEVICE_CFG: reg_mapped = 1'b1;
         default:                                         reg_mapped = 1'b0;
      endcase
   endfunction : reg_mapped

endpackage : gpio_port_pkg

// [include/reg_access_if.sv]
// Byte-register access path between the bus slave and the register file.
// Assumes one clock; strobes are single-cycle and qualified by the slave.
interface reg_access_if;
   logic                                 wr_en;
   logic [gpio_port_pkg::IDX_W-1:0]      wr_idx;
   logic [gpio_port_pkg::REG_W-1:0]      wr_data;
   logic [gpio_port_pkg::IDX_W-1:0]      rd_idx;
   logic [gpio_port_pkg::REG_W-1:0]      rd_data;

   modport bus  (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
   modport regs (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : reg_access_if

// [core/pin_mux.sv]
// Per-pin output selection between port latch and LCD segment drive.
// Assumes pin inputs already synchronous; purely combinational.
module pin_mux #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] latch,
   input  wire logic [WIDTH-1:0] dir,
   input  wire logic [WIDTH-1:0] seg_en,
   input  wire logic [WIDTH-1:0] seg_out,
   input  wire logic [WIDTH-1:0] seg_oe,
   input  wire logic [WIDTH-1:0] analog_en,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] digital_in
);
   // Segment drive overrides the latch; LCD decides its own tri-state
   assign pin_out    = (seg_en & seg_out) | (~seg_en & latch);      // R13
   assign pin_oe     = (seg_en & seg_oe) | (~seg_en & ~dir);         // R10
   // Analog-selected pins read as zero
   assign digital_in = pin_in & ~analog_en;                          // R07
endmodule : pin_mux

// [core/axil_reg_slave.sv]
// AXI4-Lite slave turning word accesses into byte register strobes.
// Assumes registers sit in byte lane 0 of aligned words; one clock.
module axil_reg_slave (
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]   awaddr,
   input  wire logic                               awvalid,
   output logic                                    awready,
   input  wire logic [gpio_port_pkg::DATA_W-1:0]   wdata,
   input  wire logic [3:0]                         wstrb,
   input  wire logic                               wvalid,
   output logic                                    wready,
   output logic [1:0]                              bresp,
   output logic                                    bvalid,
   input  wire logic                               bready,
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]   araddr,
   input  wire logic                               arvalid,
   output logic                                    arready,
   output logic [gpio_port_pkg::DATA_W-1:0]        rdata,
   output logic [1:0]                              rresp,
   output logic                                    rvalid,
   input  wire logic                               rready,
   reg_access_if.bus                               regs
);
   typedef struct packed {
      logic                              aw_held;
      logic [gpio_port_pkg::ADDR_W-1:0]  awaddr;
      logic                              w_held;
      logic [7:0]                        wdata;
      logic                              wlane;
      logic                              bvalid;
      logic [1:0]                        bresp;
      logic                              ar_held;
      logic [gpio_port_pkg::ADDR_W-1:0]  araddr;
      logic                              rvalid;
      logic [1:0]                        rresp;
      logic [gpio_port_pkg::DATA_W-1:0]  rdata;
   } slave_state_t;

   slave_state_t s_q;
   slave_state_t s_d;
   logic         wr_go;
   logic         wr_ok;
   logic         rd_ok;

   assign awready = ~s_q.aw_held & ~s_q.bvalid;
   assign wready  = ~s_q.w_held & ~s_q.bvalid;
   assign arready = ~s_q.ar_held & ~s_q.rvalid;
   assign bvalid  = s_q.bvalid;
   assign bresp   = s_q.bresp;
   assign rvalid  = s_q.rvalid;
   assign rresp   = s_q.rresp;
   assign rdata   = s_q.rdata;

   assign wr_go = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
   assign wr_ok = (s_q.awaddr[1:0] == 2'h0) & gpio_port_pkg::reg_mapped(s_q.awaddr[11:2]);
   assign rd_ok = (s_q.araddr[1:0] == 2'h0) & gpio_port_pkg::reg_mapped(s_q.araddr[11:2]);

   assign regs.wr_en   = wr_go & wr_ok & s_q.wlane;
   assign regs.wr_idx  = s_q.awaddr[11:2];
   assign regs.wr_data = s_q.wdata;
   assign regs.rd_idx  = s_q.araddr[11:2];

   always_comb begin
      s_d = s_q;
      if (awvalid && awready) begin
         s_d.aw_held = 1'b1;
         s_d.awaddr  = awaddr;
      end
      if (wvalid && wready) begin
         s_d.w_held = 1'b1;
         s_d.wdata  = wdata[7:0];
         s_d.wlane  = wstrb[0];
      end
      if (wr_go) begin
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = wr_ok ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
      end else if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_d.ar_held = 1'b1;
         s_d.araddr  = araddr;
      end else if (s_q.ar_held) begin
         s_d.ar_held = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = rd_ok ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
         s_d.rdata   = rd_ok ? {24'h000000, regs.rd_data} : 32'h00000000;
      end else if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (!aresetn) begin
         s_d = '0;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end
endmodule : axil_reg_slave

// [verif/gpio_port_sva.sv]
// Checker on the port block's ports: bus timing, reset values, master clear.
// Assumes it is bound to gpio_port and runs on aclk alone.
module gpio_port_sva (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       power_on_reset,
   input wire logic       awvalid,
   input wire logic       awready,
   input wire logic       wvalid,
   input wire logic       wready,
   input wire logic       bvalid,
   input wire logic       arvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   input wire logic       input_only_pin,
   input wire logic       master_clear_reset,
   input wire logic       weak_pullup_enable,
   input wire logic [2:0] analog_input_connect,
   input wire logic [7:0] port_d_oe,
   input wire logic [2:0] bidirectional_pins_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || power_on_reset);
   property p_master_clear_reset; weak_pullup_enable && !input_only_pin |-> master_clear_reset; endproperty
   a_master_clear_reset: assert property (p_master_clear_reset) else $error("master clear not raised");
   property p_pull; master_clear_reset |-> weak_pullup_enable && !input_only_pin; endproperty
   a_pull: assert property (p_pull) else $error("master clear without cause");
   property p_por; disable iff (1'b0)
      power_on_reset |=> port_d_oe == 8'h00 && bidirectional_pins_oe == 3'h0; endproperty
   a_por: assert property (p_por) else $error("pin driven after power-on reset");
   property p_rst; disable iff (1'b0)
      !aresetn |=> weak_pullup_enable && analog_input_connect == 3'h7; endproperty
   a_rst: assert property (p_rst) else $error("config not restored by reset");
   property p_bv; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
   a_bv: assert property (p_bv) else $error("write response timing");
   property p_rv; arvalid && arready |=> !rvalid ##1 rvalid; endproperty
   a_rv: assert property (p_rv) else $error("read response timing");
   property p_bbusy; bvalid |-> !awready && !wready; endproperty
   a_bbusy: assert property (p_bbusy) else $error("write taken while response open");
   property p_rbusy; rvalid |-> !arready; endproperty
   a_rbusy: assert property (p_rbusy) else $error("read taken while data open");
endmodule : gpio_port_sva

// [verif/pin_partner.sv]
// Far side of the pins: resolves each pad from device drive and board drive.
// Assumes the board drives every pad the device leaves released.
module pin_partner (
   input  wire logic [7:0] port_d_out,
   input  wire logic [7:0] port_d_oe,
   input  wire logic [2:0] bidirectional_pins_out,
   input  wire logic [2:0] bidirectional_pins_oe,
   input  wire logic [7:0] drive_d,
   input  wire logic [2:0] drive_e,
   output logic      [7:0] port_d_in,
   output logic      [2:0] bidirectional_pins_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pad level is the device's drive where enabled, else the board's
   assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & drive_d);
   assign bidirectional_pins_in = (bidirectional_pins_oe & bidirectional_pins_out)
                                | (~bidirectional_pins_oe & drive_e);
endmodule : pin_partner

// [verif/gpio_port_tb.sv]
// Testbench for the port block: register scenarios over the bus, pin checks.
// Assumes gpio_port, pin_partner and gpio_port_sva are compiled before it.
module gpio_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A_PD  = {gpio_port_pkg::IDX_PORT_D_PIN, 2'b00};
   localparam logic [11:0] A_PE  = {gpio_port_pkg::IDX_PORT_E_PIN, 2'b00};
   localparam logic [11:0] A_DD  = {gpio_port_pkg::IDX_PORT_D_DIR, 2'b00};
   localparam logic [11:0] A_DE  = {gpio_port_pkg::IDX_PORT_E_DIR, 2'b00};
   localparam logic [11:0] A_AN  = {gpio_port_pkg::IDX_ANALOG_SEL, 2'b00};
   localparam logic [11:0] A_SG  = {gpio_port_pkg::IDX_SEGMENT_HIGH, 2'b00};
   localparam logic [11:0] A_CF  = {gpio_port_pkg::IDX_DEVICE_CFG, 2'b00};
   localparam logic [11:0] A_BAD = 12'h7F0;
   localparam logic [1:0]  OK    = gpio_port_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR   = gpio_port_pkg::RESP_SLVERR;
   logic        aclk, aresetn, power_on_reset, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, input_only_pin;
   logic        master_clear_reset, weak_pullup_enable;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [7:0]  port_d_in, port_d_out, port_d_oe, lcd_segment_out, lcd_segment_oe, drive_d;
   logic [2:0]  bidirectional_pins_in, bidirectional_pins_out, bidirectional_pins_oe;
   logic [2:0]  analog_input_connect, drive_e;
   int          n_fail, checks;

   gpio_port uut (.aclk, .aresetn, .power_on_reset, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .port_d_in, .port_d_out, .port_d_oe, .bidirectional_pins_in,
      .bidirectional_pins_out, .bidirectional_pins_oe, .input_only_pin, .lcd_segment_out,
      .lcd_segment_oe, .analog_input_connect, .master_clear_reset, .weak_pullup_enable);
   pin_partner far (.port_d_out, .port_d_oe, .bidirectional_pins_out, .bidirectional_pins_oe,
      .drive_d, .drive_e, .port_d_in, .bidirectional_pins_in);

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("Counts: %0d comparisons, %0d mismatches", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   // One bus write; address and data offered together, released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 40) begin
         n_fail++;
         close_out();
      end
      chk(bresp, er);
      bready <= 1'b0;
   endtask : wr

   // One bus read, data and response compared at the handshake edge
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 40) begin
         n_fail++;
         close_out();
      end
      chk(rdata, ed);
      chk(rresp, er);
      rready <= 1'b0;
   endtask : rd

   task automatic t_reset();
      rd(A_DD, 32'h000000FF, OK);
      rd(A_DE, 32'h0000000F, OK);
      rd(A_SG, 32'h00000000, OK);
      rd(A_BAD, 32'h00000000, ERR);
      chk(bidirectional_pins_oe, 3'h0);
      chk(analog_input_connect, 3'h7);
      $display("done: reset values");
   endtask : t_reset

   task automatic t_port_e();
      wr(A_AN, 32'h00000000, 4'hF, OK);
      chk(analog_input_connect, 3'h0);
      wr(A_DE, 32'h000000F2, 4'hF, OK);
      rd(A_DE, 32'h0000000A, OK);
      wr(A_PE, 32'h00000005, 4'hF, OK);
      chk(bidirectional_pins_out, 3'h5);
      chk(bidirectional_pins_oe, 3'h5);
      drive_e <= 3'h6;
      input_only_pin <= 1'b1;
      rd(A_PE, 32'h00000007, OK);
      wr(A_CF, 32'h00000000, 4'hF, OK);
      chk(weak_pullup_enable, 1'b0);
      rd(A_PE, 32'h0000000F, OK);
      wr(A_AN, 32'h00000020, 4'hF, OK);
      chk(analog_input_connect, 3'h1);
      rd(A_PE, 32'h0000000E, OK);
      wr(A_CF, 32'h00000001, 4'hF, OK);
      input_only_pin <= 1'b0;
      @(posedge aclk);
      chk(master_clear_reset, 1'b1);
      input_only_pin <= 1'b1;
      $display("done: port E");
   endtask : t_port_e

   task automatic t_port_d_seg();
      wr(A_DD, 32'h0000000F, 4'hF, OK);
      drive_d <= 8'h3C;
      wr(A_PD, 32'h000000A5, 4'hF, OK);
      rd(A_PD, 32'h000000AC, OK);
      chk(port_d_oe, 8'hF0);
      chk(port_d_out, 8'hA5);
      lcd_segment_out <= 8'hA1;
      lcd_segment_oe <= 8'h61;
      wr(A_SG, 32'h000000E1, 4'hF, OK);
      chk(bidirectional_pins_out, 3'h5);
      chk(bidirectional_pins_oe, 3'h3);
      chk(port_d_oe, 8'hF8);
      chk(port_d_out, 8'hAD);
      $display("done: port D and segments");
   endtask : t_port_d_seg

   task automatic t_resets();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_SG, 32'h000000E1, OK);
      rd(A_DE, 32'h0000000F, OK);
      rd(A_DD, 32'h000000FF, OK);
      power_on_reset <= 1'b1;
      repeat (2) @(posedge aclk);
      power_on_reset <= 1'b0;
      rd(A_SG, 32'h00000000, OK);
      wr(A_SG, 32'h000000FF, 4'h0, OK);
      rd(A_SG, 32'h00000000, OK);
      wr(A_BAD, 32'h000000FF, 4'hF, ERR);
      $display("done: resets");
   endtask : t_resets

   initial begin
      aresetn = 1'b0;
      power_on_reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      input_only_pin = 1'b1;
      lcd_segment_out = 8'h00;
      lcd_segment_oe = 8'h00;
      drive_d = 8'h00;
      drive_e = 3'h0;
      n_fail = 0;
      checks = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      power_on_reset <= 1'b0;
      t_reset();
      t_port_e();
      t_port_d_seg();
      t_resets();
      close_out();
   end
endmodule : gpio_port_tb

bind gpio_port gpio_port_sva chk_i (.aclk, .aresetn, .power_on_reset, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .input_only_pin,
   .master_clear_reset, .weak_pullup_enable, .analog_input_connect, .port_d_oe,
   .bidirectional_pins_oe);
